// ==== wpt_map.vh ====
// constants for the identification and core configuration register pair
// assumes a 200 MHz system clock and a 7-bit I2C slave address
//
// Functional notes
// RL1: irq polarity bit sets interrupt pin active level
// RL2: sleep polarity bit selects sleep input active level
// RL3: reset kind bit: 0 soft, 1 hard, reset 1
// RL4: oscillator bit enables crystal oscillator, reset 1
// RL5: timeout field: off, 0.309, 1.237, 9.896 s
// RL6: four-bit revision field, top bit marks production
// RL7: address select bit sets slave address top bit
`ifndef WPT_MAP_VH
`define WPT_MAP_VH

// register offsets
`define WPT_REVISION_FEATURE_IDENT_OFS 8'h0B
`define WPT_CORE_CONFIGURATION_OFS     8'h10
`define WPT_CORE_CONFIGURATION_RST     8'h0C
`define WPT_UNMAPPED_RDATA             8'h00

// core configuration fields
`define WPT_IRQ_POLARITY_BIT     0
`define WPT_SLEEP_POLARITY_BIT   1
`define WPT_RESET_KIND_BIT       2
`define WPT_XTAL_OSC_BIT         3
`define WPT_TIMEOUT_LO           4
`define WPT_TIMEOUT_HI           5
`define WPT_SLAVE_ADDR_TOP_BIT   7

// timeout codes
`define WPT_TMO_OFF   2'h0
`define WPT_TMO_SHORT 2'h1
`define WPT_TMO_MID   2'h2
`define WPT_TMO_LONG  2'h3

// timeout periods in microseconds and the clock rate
// sized to the 31-bit cycle counters so the products need no truncation
`define WPT_TMO_SHORT_US 31'd309000
`define WPT_TMO_MID_US   31'd1237000
`define WPT_TMO_LONG_US  31'd9896000
`define WPT_CLK_MHZ      31'd200

// i2c framing
`define WPT_BIT_LAST 3'h7
`define WPT_TMO_W    31

`endif

// ==== wpt_sync.v ====
// three-stage synchroniser with agreement filter for pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module wpt_sync #(
   parameter       W   = 1,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   // clock and reset
   input  wire         clk,
   input  wire         reset_n,
   // raw and filtered levels
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   integer     i;

   // first stage feeds only the second; output moves when stages two and three agree
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q     <= RST;
         s2_q     <= RST;
         s3_q     <= RST;
         sync_out <= RST;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (i = 0; i < W; i = i + 1) begin
            if (s2_q[i] == s3_q[i]) begin
               sync_out[i] <= s3_q[i];
            end
         end
      end
   end
endmodule // wpt_sync
`default_nettype wire

// ==== wpt_id_cfg_regs.v ====
// identification and core configuration registers behind an I2C slave
// assumes SCL/SDA/sleep pins are asynchronous; irq request is on MCLK
`timescale 1ns/1ps
`default_nettype none
`include "wpt_map.vh"
module wpt_id_cfg_regs #(
   parameter [3:0] SILICON_REVISION = 4'h3,   // arbitrary value
   parameter [3:0] FEATURE_CONFIG   = 4'h5,   // arbitrary value
   parameter [5:0] SLAVE_ADDR_LOW   = 6'h1A,  // arbitrary low address bits
   parameter [30:0] TMO_SHORT_CYC = `WPT_TMO_SHORT_US * `WPT_CLK_MHZ,
   parameter [30:0] TMO_MID_CYC   = `WPT_TMO_MID_US * `WPT_CLK_MHZ,
   parameter [30:0] TMO_LONG_CYC  = `WPT_TMO_LONG_US * `WPT_CLK_MHZ
) (
   // clock and reset
   input  wire MCLK,
   input  wire RESET_N,
   // i2c pins, sda open drain
   input  wire SCL_I,
   input  wire SDA_I,
   output reg  SDA_O,
   output reg  SDA_OE,
   // interrupt request from device logic and the pin it drives
   input  wire IRQ_REQUEST,
   output reg  IRQ_OUT_PIN,
   // sleep request pin and resulting mode
   input  wire SLEEP_REQUEST_PIN,
   output reg  SLEEP_MODE,
   // configuration outputs to the rest of the device
   output reg  RESET_KIND_HARD,
   output reg  XTAL_OSC_ON
);
   // one-hot i2c states
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_ADDR = 7'h02;
   localparam [6:0] ST_ACK  = 7'h04;
   localparam [6:0] ST_ACKH = 7'h08;
   localparam [6:0] ST_WR   = 7'h10;
   localparam [6:0] ST_RD   = 7'h20;
   localparam [6:0] ST_RACK = 7'h40;

   reg  [6:0]  state_q;
   reg  [7:0]  cfg_q;
   reg  [7:0]  ptr_q;
   reg  [7:0]  sh_q;
   reg  [2:0]  bitcnt_q;
   reg         rw_q;
   reg         first_q;
   reg         scl_d1_q;
   reg         sda_d1_q;
   reg  [30:0] tmo_cnt_q;
   wire        scl_s;
   wire        sda_s;
   wire        sleep_s;
   wire        scl_rise;
   wire        scl_fall;
   wire        start_c;
   wire        stop_c;
   wire [7:0]  byte_c;
   wire [6:0]  my_addr;
   wire [1:0]  tmo_sel;
   wire [30:0] tmo_lim;
   wire [7:0]  rd_byte;

   // pin synchronisers; idle bus levels are high
   wpt_sync #(.W(3), .RST(3'h3)) u_sync (
      .clk      (MCLK),
      .reset_n  (RESET_N),
      .async_in ({SLEEP_REQUEST_PIN, SDA_I, SCL_I}),
      .sync_out ({sleep_s, sda_s, scl_s})
   );

   // register read mux, unmapped offsets read as zero
   function [7:0] reg_read;
      input [7:0] ofs;
      input [7:0] cfg;
      begin
         case (ofs)
            `WPT_REVISION_FEATURE_IDENT_OFS: reg_read = {FEATURE_CONFIG, SILICON_REVISION}; // [RL6]
            `WPT_CORE_CONFIGURATION_OFS:     reg_read = cfg;
            default:                         reg_read = `WPT_UNMAPPED_RDATA;
         endcase
      end
   endfunction

   // timeout period per code; zero means disabled
   function [30:0] tmo_limit;
      input [1:0] sel;
      begin
         case (sel)
            `WPT_TMO_SHORT: tmo_limit = TMO_SHORT_CYC;  // [RL5]
            `WPT_TMO_MID:   tmo_limit = TMO_MID_CYC;    // [RL5]
            `WPT_TMO_LONG:  tmo_limit = TMO_LONG_CYC;   // [RL5]
            default:        tmo_limit = 31'h00000000;   // [RL5]
         endcase
      end
   endfunction

   // bus events on filtered levels
   assign scl_rise = scl_s & ~scl_d1_q;
   assign scl_fall = ~scl_s & scl_d1_q;
   assign start_c  = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
   assign stop_c   = scl_s & scl_d1_q & ~sda_d1_q & sda_s;
   assign byte_c   = {sh_q[6:0], sda_s};
   assign my_addr  = {cfg_q[`WPT_SLAVE_ADDR_TOP_BIT], SLAVE_ADDR_LOW}; // [RL7]
   assign tmo_sel  = cfg_q[`WPT_TIMEOUT_HI:`WPT_TIMEOUT_LO];
   assign tmo_lim  = tmo_limit(tmo_sel);
   assign rd_byte  = reg_read(ptr_q, cfg_q);  // byte the pointer selects for a read

   // edge history
   always @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         scl_d1_q <= 1'b1;
         sda_d1_q <= 1'b1;
      end else begin
         scl_d1_q <= scl_s;
         sda_d1_q <= sda_s;
      end
   end

   // stuck-clock timeout counts only while a transfer holds scl low
   always @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tmo_cnt_q <= 31'h00000000;
      end else if (state_q == ST_IDLE || scl_s || tmo_cnt_q == tmo_lim) begin
         tmo_cnt_q <= 31'h00000000;
      end else begin
         tmo_cnt_q <= tmo_cnt_q + 31'h00000001;
      end
   end

   // i2c slave and register writes
   always @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_q  <= ST_IDLE;
         cfg_q    <= `WPT_CORE_CONFIGURATION_RST;  // [RL3] [RL4]
         ptr_q    <= 8'h00;
         sh_q     <= 8'h00;
         bitcnt_q <= 3'h0;
         rw_q     <= 1'b0;
         first_q  <= 1'b0;
         SDA_OE   <= 1'b0;
      end else if (start_c) begin
         state_q  <= ST_ADDR;
         bitcnt_q <= 3'h0;
         first_q  <= 1'b1;
         SDA_OE   <= 1'b0;
      end else if (stop_c || (tmo_sel != `WPT_TMO_OFF && tmo_cnt_q == tmo_lim &&
                              state_q != ST_IDLE)) begin
         state_q <= ST_IDLE;   // [RL5] abandon a stalled transfer
         SDA_OE  <= 1'b0;
      end else begin
         case (state_q)
            ST_ADDR, ST_WR: begin
               if (scl_rise) begin
                  sh_q     <= byte_c;
                  bitcnt_q <= bitcnt_q + 3'h1;
                  if (bitcnt_q == `WPT_BIT_LAST) begin
                     if (state_q == ST_ADDR) begin
                        // address changes take effect on the next start
                        if (byte_c[7:1] == my_addr) begin  // [RL7]
                           rw_q    <= byte_c[0];
                           state_q <= ST_ACK;
                        end else begin
                           state_q <= ST_IDLE;
                        end
                     end else begin
                        state_q <= ST_ACK;
                        first_q <= 1'b0;
                        if (first_q) begin
                           ptr_q <= byte_c;
                        end else begin
                           if (ptr_q == `WPT_CORE_CONFIGURATION_OFS) begin
                              cfg_q <= byte_c;  // [RL1] [RL2] [RL3] [RL4] [RL5] [RL7]
                           end
                           ptr_q <= ptr_q + 8'h01;
                        end
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  SDA_OE  <= 1'b1;
                  state_q <= ST_ACKH;
               end
            end
            ST_ACKH: begin
               // release ack, or present the first read bit on the same fall
               if (scl_fall) begin
                  bitcnt_q <= 3'h0;
                  if (rw_q) begin
                     sh_q    <= rd_byte;
                     SDA_OE  <= ~rd_byte[7];  // pull low for a zero msb
                     state_q <= ST_RD;
                  end else begin
                     SDA_OE  <= 1'b0;
                     state_q <= ST_WR;
                  end
               end
            end
            ST_RD: begin
               if (scl_rise) begin
                  bitcnt_q <= bitcnt_q + 3'h1;
                  if (bitcnt_q == `WPT_BIT_LAST) begin
                     state_q <= ST_RACK;
                  end
               end else if (scl_fall) begin
                  sh_q   <= {sh_q[6:0], 1'b0};
                  SDA_OE <= ~sh_q[6];
               end
            end
            ST_RACK: begin
               // master ack continues with the next offset, nack ends the read
               if (scl_fall) begin
                  SDA_OE <= 1'b0;
               end else if (scl_rise) begin
                  if (!sda_s) begin
                     ptr_q   <= ptr_q + 8'h01;
                     state_q <= ST_ACKH;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_IDLE: begin
               SDA_OE <= 1'b0;
            end
            default: begin
               state_q <= ST_IDLE;
               SDA_OE  <= 1'b0;
            end
         endcase
      end
   end

   // pin and configuration outputs, all registered
   always @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SDA_O           <= 1'b0;
         IRQ_OUT_PIN     <= 1'b1;
         SLEEP_MODE      <= 1'b0;
         RESET_KIND_HARD <= 1'b1;
         XTAL_OSC_ON     <= 1'b1;
      end else begin
         SDA_O           <= 1'b0;  // open drain: only ever pulls low
         IRQ_OUT_PIN     <= ~(IRQ_REQUEST ^ cfg_q[`WPT_IRQ_POLARITY_BIT]);  // [RL1]
         SLEEP_MODE      <= sleep_s ^ cfg_q[`WPT_SLEEP_POLARITY_BIT];       // [RL2]
         RESET_KIND_HARD <= cfg_q[`WPT_RESET_KIND_BIT];                     // [RL3]
         XTAL_OSC_ON     <= cfg_q[`WPT_XTAL_OSC_BIT];                       // [RL4]
      end
   end
endmodule // wpt_id_cfg_regs
`default_nettype wire

// ==== wpt_chk_assertions.sv ====
// port assertions for the identification and configuration pair
// assumes SDA_I carries the resolved open-drain wire level
`timescale 1ns/1ps
`default_nettype none
module wpt_chk (
   // clock and reset
   input wire logic MCLK,
   input wire logic RESET_N,
   // pins
   input wire logic SCL_I,
   input wire logic SDA_I,
   input wire logic SDA_O,
   input wire logic SDA_OE,
   input wire logic IRQ_REQUEST,
   input wire logic IRQ_OUT_PIN,
   input wire logic SLEEP_REQUEST_PIN,
   input wire logic SLEEP_MODE,
   input wire logic RESET_KIND_HARD,
   input wire logic XTAL_OSC_ON
);
   logic [3:0] idle_q;
   logic       req_q;
   wire        idle = (idle_q > 4'h8);
   // idle bus count; config can only move while the host talks
   always @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         idle_q <= 4'h0;
         req_q  <= 1'b0;
      end else begin
         idle_q <= (SCL_I && SDA_I) ? idle_q + {3'h0, idle_q != 4'hF} : 4'h0;
         req_q  <= IRQ_REQUEST;
      end
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   a_rst_values: assert property ($rose(RESET_N) |-> RESET_KIND_HARD && XTAL_OSC_ON)
      else $error("config outputs not at reset value");
   a_irq_after_reset: assert property ($rose(RESET_N) |=> IRQ_OUT_PIN != req_q)
      else $error("irq pin not active low after reset");
   a_irq_pol_hold: assert property (idle |-> $stable(IRQ_OUT_PIN ^ req_q))
      else $error("irq polarity moved on idle bus");
   a_sleep_pol_hold: assert property ($stable(SLEEP_REQUEST_PIN)[*8] ##0 idle |-> $stable(SLEEP_MODE))
      else $error("sleep mode moved without cause");
   a_cfg_idle_hold: assert property (idle |-> $stable({RESET_KIND_HARD, XTAL_OSC_ON}))
      else $error("config outputs moved on idle bus");
   a_sda_open_drain: assert property (SDA_OE |-> !SDA_O)
      else $error("sda driven high");
   a_sda_scl_low: assert property ($changed(SDA_OE) |-> !SCL_I)
      else $error("sda moved while scl high");
   cover property ($rose(SDA_OE));
   cover property ($fell(RESET_KIND_HARD));
   cover property ($rose(SLEEP_MODE));
endmodule // wpt_chk
`default_nettype wire

// ==== wpt_host.sv ====
// host model: drives SCL and its own pull on the SDA wire
// assumes dev_pull is high while the device holds SDA low
`timescale 1ns/1ps
`default_nettype none
module wpt_host (
   // clock
   input  wire logic clk,
   // wire levels
   input  wire logic dev_pull,
   output var  logic scl,
   output wire logic sda
);
   logic host_low = 1'b0;
   // pull-up wire, so a released line reads high
   assign sda = !(host_low || dev_pull);
   initial scl = 1'b1;
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ten-cycle phases; data moves only while scl is low
   task automatic bit_io(input logic b, output logic r);
      host_low <= !b;
      hold(10);
      scl <= 1'b1;
      hold(10);
      r = sda;
      scl <= 1'b0;
      hold(2);
   endtask
   task automatic start;
      host_low <= 1'b0;
      hold(10);
      scl <= 1'b1;
      hold(10);
      host_low <= 1'b1;
      hold(10);
      scl <= 1'b0;
      hold(2);
   endtask
   task automatic stop;
      host_low <= 1'b1;
      hold(10);
      scl <= 1'b1;
      hold(10);
      host_low <= 1'b0;
      hold(10);
   endtask
   // msb first, then the ninth bit
   task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ma, k);
   endtask
endmodule // wpt_host
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the identification and configuration pair
// assumes the host model resolves the SDA wire
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       mclk = 1'b0, rst_n, irq_req, sleep_request_pin, scl, sda, sda_o, sda_oe;
   logic       irq_pin, slp_mode, hard, osc, ak;
   logic [7:0] q;
   int         err_count = 0, total_checks = 0, cyc = 0;
   wpt_id_cfg_regs #(.SILICON_REVISION(4'hB), .TMO_SHORT_CYC(31'd200),
      .TMO_MID_CYC(31'd400), .TMO_LONG_CYC(31'd800)) u_dut (.MCLK(mclk), .RESET_N(rst_n),
      .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .IRQ_REQUEST(irq_req),
      .IRQ_OUT_PIN(irq_pin), .SLEEP_REQUEST_PIN(sleep_request_pin), .SLEEP_MODE(slp_mode),
      .RESET_KIND_HARD(hard), .XTAL_OSC_ON(osc));
   wpt_host h (.clk(mclk), .dev_pull(sda_oe), .scl(scl), .sda(sda));
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d);
      logic k0, k1, k2;
      h.start();
      h.xfer({a, 1'b0}, 1'b1, q, k0);
      h.xfer(o, 1'b1, q, k1);
      h.xfer(d, 1'b1, q, k2);
      h.stop();
      ak = !(k0 | k1 | k2);
   endtask
   // keep leaves the device driving the first data bit
   task automatic rd(input logic [6:0] a, input logic [7:0] o, input logic keep);
      logic k0, k1, k2;
      h.start();
      h.xfer({a, 1'b0}, 1'b1, q, k0);
      h.xfer(o, 1'b1, q, k1);
      h.start();
      h.xfer({a, 1'b1}, 1'b1, q, k2);
      ak = !(k0 | k1 | k2);
      if (!keep) begin
         h.xfer(8'hFF, 1'b1, q, k0);
         h.stop();
      end
   endtask
   // 200 MHz clock and a hang limit well past the expected run
   initial forever #2.5 mclk = !mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      rst_n <= 1'b0;
      irq_req <= 1'b0;
      sleep_request_pin <= 1'b0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (8) @(posedge mclk);
      rd(7'h1A, 8'h10, 1'b0);
      check("cfg reset", q, 8'h0C);
      wr(7'h1A, 8'h0B, 8'h00);
      rd(7'h1A, 8'h0B, 1'b0);
      check("ident", q, 8'h5B);
      rd(7'h1A, 8'h20, 1'b0);
      check("unmapped", q, 8'h00);
      // two-byte read with master ack: pointer moves on to the config register
      rd(7'h1A, 8'h0F, 1'b1);
      h.xfer(8'hFF, 1'b0, q, ak);
      check("burst first", q, 8'h00);
      h.xfer(8'hFF, 1'b1, q, ak);
      h.stop();
      check("burst second", q, 8'h0C);
      $display("test identity done");
      for (int i = 0; i < 4; i++) begin
         wr(7'h1A, 8'h10, {4'h0, i[1:0], i[0], i[1]});
         check("modes", {6'h0, hard, osc}, {6'h0, i[0], i[1]});
         for (int p = 0; p < 2; p++) begin
            sleep_request_pin <= p[0];
            irq_req <= p[0];
            repeat (10) @(posedge mclk);
            check("sleep", {7'h0, slp_mode}, {7'h0, p[0] ^ i[0]});
            check("irq pin", {7'h0, irq_pin}, {7'h0, p[0] ~^ i[1]});
         end
      end
      $display("test polarity done");
      wr(7'h1A, 8'h10, 8'h8C);
      rd(7'h1A, 8'h10, 1'b0);
      check("old addr", {7'h0, ak}, 8'h00);
      rd(7'h5A, 8'h10, 1'b0);
      check("new addr", q, 8'h8C);
      $display("test address done");
      // timeout codes 1..3, then code 0 that never lets go
      for (int c = 1; c < 5; c++) begin
         wr((c == 1) ? 7'h5A : 7'h1A, 8'h10, {2'h0, c[1:0], 4'hC});
         rd(7'h1A, 8'h10, 1'b1);
         repeat ((c < 4) ? (100 << c) - 50 : 1000) @(posedge mclk);
         check("held", {7'h0, sda_oe}, 8'h01);
         if (c < 4) begin
            repeat (110) @(posedge mclk);
            check("released", {7'h0, sda_oe}, 8'h00);
            h.stop();
         end
      end
      rst_n <= 1'b0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      h.stop();
      rd(7'h1A, 8'h10, 1'b0);
      check("cfg second reset", q, 8'h0C);
      $display("test timeout done");
      give_verdict();
   end
endmodule // tb_top
bind wpt_id_cfg_regs wpt_chk u_chk (.MCLK, .RESET_N, .SCL_I, .SDA_I, .SDA_O, .SDA_OE,
   .IRQ_REQUEST, .IRQ_OUT_PIN, .SLEEP_REQUEST_PIN, .SLEEP_MODE, .RESET_KIND_HARD, .XTAL_OSC_ON);
`default_nettype wire
